// File: src/mcid_top.sv
// Capability report register of the I/O memory management unit.
// Assumes a plain register port: strobes one cycle, read data next cycle.
`timescale 1ns/10ps
module mcid_top
  import mcid_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic      [1:0]        ns_stall_model,
  output logic                   nonsecure_stall_disable,
  output logic                   cap_coerced
);
  // =========================================
  // Declarations
  logic        stall_dis_r;
  logic [1:0]  stall_model_r;
  logic        coerced_r;
  logic [1:0]  stall_model;
  logic        stall_coerced;
  logic [1:0]  stream_table_levels;
  logic        term_abort_only;
  logic [1:0]  walk_endianness;
  logic        virtual_xlate_page;
  logic        two_level_context_table;
  logic        wide_vm_tag;
  logic        vm_tag_wildcard;
  logic        page_request;
  logic        xlate_operations;
  logic        wake_event_support;
  logic        msi_support;
  logic        wide_space_tag;
  logic        split_stage_xlate_off;
  logic        ats_support;
  logic        hyp_contexts;
  logic        dormant_hint;
  logic [1:0]  hw_table_flag_update;
  logic        broadcast_tlb_maint;
  logic        coherent_access;
  logic [1:0]  table_formats;
  logic        stage1_present;
  logic        stage2_present;
  logic        both_stages;
  logic        fix_coerced;
  logic [31:0] feature_word;
  logic [31:0] ctrl_word;
  logic [31:0] sec_word;

  // =========================================
  // Secure control register
  // RULE4: stall disable control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_dis_r <= RST_STALL_DIS;
    end else if (reg_wr && reg_addr == OFS_SEC_CTRL) begin
      stall_dis_r <= reg_wdata[POS_STALL_DIS];
    end
  end

  // RULE23: report writes ignored
  // A write to the report offset, or to the read-only secure
  // copy, reaches no storage at all.

  // =========================================
  // Stage presence
  // RULE22: stage bits
  always_comb begin
    stage1_present = CAP_S1;
    stage2_present = CAP_S2;
    both_stages    = CAP_S1 & CAP_S2;
  end

  // =========================================
  // Stream and context tables
  always_comb begin
    // RULE1: stream levels code
    if (CAP_ST_LEVELS[1]) begin
      stream_table_levels = LVL_LINEAR;
    end else begin
      stream_table_levels = CAP_ST_LEVELS;
    end
    // RULE8: two-level contexts
    two_level_context_table = CAP_CTX2L;
    // RULE2: terminate model
    term_abort_only = CAP_TERM_ABORT;
  end

  // =========================================
  // Stall model
  // RULE3: stall code resolve
  mcid_stall_sel u_stall (
    .secure_side_present     (CAP_SECURE),
    .pci_system              (CAP_PCI_SYS),
    .own_model               (CAP_STALL),
    .secure_model            (CAP_SEC_STALL),
    .nonsecure_stall_disable (stall_dis_r),
    .model                   (stall_model),
    .coerced                 (stall_coerced)
  );

  // =========================================
  // Walk endianness
  always_comb begin
    // RULE6: endianness code
    if (CAP_ENDIAN == 2'h1) begin
      walk_endianness = ENDIAN_MIXED;
    end else begin
      walk_endianness = CAP_ENDIAN;
    end
  end

  // =========================================
  // Translation operations
  always_comb begin
    // RULE12: translate operations
    xlate_operations = CAP_XLATE;
    // RULE7: virtual page gating
    virtual_xlate_page = CAP_VXLATE & CAP_XLATE & both_stages;
  end

  // =========================================
  // Tag widths and invalidation
  always_comb begin
    // RULE9: wide tag bits
    wide_vm_tag    = CAP_WVM;
    wide_space_tag = CAP_WSPACE;
    // RULE10: wildcard needs stage 2
    vm_tag_wildcard = CAP_VMWILD & CAP_S2;
  end

  // =========================================
  // ATS, page requests and split stage
  always_comb begin
    // RULE16: unit ATS only
    ats_support = CAP_ATS;
    // RULE11: page requests need ATS
    page_request = CAP_PRI & CAP_ATS;
    // RULE15: split-stage gating
    split_stage_xlate_off = CAP_SPLIT_OFF & CAP_ATS & both_stages;
  end

  // =========================================
  // Hypervisor contexts
  always_comb begin
    // RULE17: hypervisor gating
    if (both_stages) begin
      hyp_contexts = CAP_HYP | CAP_VER32;
    end else begin
      hyp_contexts = 1'b0;
    end
    dormant_hint = CAP_DORMANT;
  end

  // =========================================
  // Events and interrupts
  always_comb begin
    // RULE13: wake events system-wide
    wake_event_support = CAP_WAKE & CAP_SYS_WAKE;
    // RULE14: message interrupts
    msi_support = CAP_MSI;
  end

  // =========================================
  // System-level features
  always_comb begin
    // RULE18: flag update code
    if (CAP_HWFLAG == 2'h3 || !CAP_SYS_ATOMIC) begin
      hw_table_flag_update = FLAG_NONE;
    end else begin
      hw_table_flag_update = CAP_HWFLAG;
    end
    // RULE19: broadcast maintenance
    broadcast_tlb_maint = CAP_BTM & CAP_SYS_BCAST;
    // RULE20: coherent access
    coherent_access = CAP_COH & CAP_SYS_COH;
  end

  // =========================================
  // Table formats
  always_comb begin
    // RULE21: table format code
    if (CAP_TTF == 2'h0) begin
      table_formats = TTF_64;
    end else begin
      table_formats = CAP_TTF;
    end
  end

  // =========================================
  // Detection of capability codes that had to be altered
  always_comb begin
    fix_coerced = 1'b0;
    if (CAP_ST_LEVELS[1]) begin
      fix_coerced = 1'b1;
    end
    if (CAP_ENDIAN == 2'h1) begin
      fix_coerced = 1'b1;
    end
    if (CAP_HWFLAG == 2'h3) begin
      fix_coerced = 1'b1;
    end
    if (CAP_TTF == 2'h0) begin
      fix_coerced = 1'b1;
    end
    if (stall_coerced) begin
      fix_coerced = 1'b1;
    end
  end

  // =========================================
  // Report word assembly
  always_comb begin
    feature_word = 32'h0;
    feature_word[POS_ST_LVL+:2]  = stream_table_levels;
    feature_word[POS_TERM]       = term_abort_only;
    // RULE4: live stall field
    feature_word[POS_STALL+:2]   = stall_model;
    feature_word[POS_ENDIAN+:2]  = walk_endianness;
    feature_word[POS_VXLATE]     = virtual_xlate_page;
    feature_word[POS_CTX2L]      = two_level_context_table;
    feature_word[POS_WVM]        = wide_vm_tag;
    feature_word[POS_VMWILD]     = vm_tag_wildcard;
    feature_word[POS_PRI]        = page_request;
    feature_word[POS_XLATE]      = xlate_operations;
    feature_word[POS_WAKE]       = wake_event_support;
    feature_word[POS_MSI]        = msi_support;
    feature_word[POS_WSPACE]     = wide_space_tag;
    feature_word[POS_SPLIT]      = split_stage_xlate_off;
    feature_word[POS_ATS]        = ats_support;
    feature_word[POS_HYP]        = hyp_contexts;
    feature_word[POS_DORM]       = dormant_hint;
    feature_word[POS_HWFLAG+:2]  = hw_table_flag_update;
    feature_word[POS_BTM]        = broadcast_tlb_maint;
    feature_word[POS_COH]        = coherent_access;
    feature_word[POS_TTF+:2]     = table_formats;
    feature_word[POS_S1]         = stage1_present;
    feature_word[POS_S2]         = stage2_present;
  end

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[POS_STALL_DIS] = stall_dis_r;
    sec_word = 32'h0;
    sec_word[POS_STALL+:2] = CAP_SEC_STALL;
  end

  // =========================================
  // Register read port
  mcid_rd_port u_rd (
    .clk          (clk),
    .resetn       (resetn),
    .rd           (reg_rd),
    .addr         (reg_addr),
    .feature_word (feature_word),
    .ctrl_word    (ctrl_word),
    .sec_word     (sec_word),
    .rdata        (reg_rdata)
  );

  // =========================================
  // Status outputs toward the rest of the unit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stall_model_r <= RST_STALL_MODEL;
      coerced_r     <= 1'b0;
    end else begin
      stall_model_r <= stall_model;
      coerced_r     <= fix_coerced;
    end
  end

  assign ns_stall_model          = stall_model_r;
  assign nonsecure_stall_disable = stall_dis_r;
  assign cap_coerced             = coerced_r;
endmodule

// File: src/mcid_pkg.sv
// Constants for the capability report of the I/O memory management unit.
// Assumes one 25 MHz clock and the active-low reset resetn.
//
// Function
// RULE1: Stream table levels, bits 28:27: 00 linear, 01 two-level, 1x reserved.
// RULE2: Bit 26: 0 abort flag selects, 1 terminated transactions always abort.
// RULE3: Stall field 25:24: 00 both, 01 no stall, 10 forced, 11 reserved.
// RULE4: With secure side, mirror secure copy; 00 plus stall disable reads 01.
// RULE5: A PCI-attached unit never reports forced stall 10.
// RULE6: Walk endianness 22:21: 00 mixed, 01 reserved, 10 little, 11 big.
// RULE7: Bit 20 virtual translate page needs translate operations and both stages.
// RULE8: Bit 19 is 1 only with two-level context tables.
// RULE9: Bits 18 and 12 report wide VM and address-space tags.
// RULE10: Bit 17 VM tag wildcard reads 0 without stage 2.
// RULE11: Bit 16 page requests reads 0 without ATS.
// RULE12: Bit 15 translate operations; when 0 bit 20 reads 0.
// RULE13: Bit 14 set only if wake events reach every maintenance processor.
// RULE14: Bit 13 reports message-signalled interrupt support.
// RULE15: Bit 11 split-stage ATS off; reads 0 unless ATS and both stages.
// RULE16: Bit 10 reports unit ATS support only.
// RULE17: Bit 9 hypervisor contexts; 0 unless both stages; mandatory at version 3.2.
// RULE18: Flag update 7:6: 00 none, 01 access, 10 dirty; 00 without atomics.
// RULE19: Bit 5 broadcast maintenance only with unit, system and interconnect support.
// RULE20: Bit 4 coherent access only if fully supported everywhere.
// RULE21: Table formats 3:2: 01 32-bit, 10 64-bit, 11 both, 00 reserved.
// RULE22: Bit 1 stage 1 present, bit 0 stage 2 present.
// RULE23: Writes to the report are ignored; fields constant except stall field.
package mcid_pkg;
  // =========================================
  // Register map (byte addresses)
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFS_FEATURE0    = 12'h000;
  localparam logic [11:0] OFS_SEC_CTRL    = 12'h004;
  localparam logic [11:0] OFS_SEC_FEATURE = 12'h008;
  localparam logic        RST_STALL_DIS   = 1'b0;
  localparam logic [1:0]  RST_STALL_MODEL = 2'h0;
  localparam int          POS_STALL_DIS   = 0;
  // =========================================
  // Field positions of the report word
  localparam int POS_ST_LVL  = 27;
  localparam int POS_TERM    = 26;
  localparam int POS_STALL   = 24;
  localparam int POS_ENDIAN  = 21;
  localparam int POS_VXLATE  = 20;
  localparam int POS_CTX2L   = 19;
  localparam int POS_WVM     = 18;
  localparam int POS_VMWILD  = 17;
  localparam int POS_PRI     = 16;
  localparam int POS_XLATE   = 15;
  localparam int POS_WAKE    = 14;
  localparam int POS_MSI     = 13;
  localparam int POS_WSPACE  = 12;
  localparam int POS_SPLIT   = 11;
  localparam int POS_ATS     = 10;
  localparam int POS_HYP     = 9;
  localparam int POS_DORM    = 8;
  localparam int POS_HWFLAG  = 6;
  localparam int POS_BTM     = 5;
  localparam int POS_COH     = 4;
  localparam int POS_TTF     = 2;
  localparam int POS_S1      = 1;
  localparam int POS_S2      = 0;
  // =========================================
  // Encodings
  localparam logic [1:0] STALL_BOTH   = 2'h0;
  localparam logic [1:0] STALL_NONE   = 2'h1;
  localparam logic [1:0] STALL_FORCED = 2'h2;
  localparam logic [1:0] ENDIAN_MIXED = 2'h0;
  localparam logic [1:0] FLAG_NONE    = 2'h0;
  localparam logic [1:0] TTF_64       = 2'h2;
  localparam logic [1:0] LVL_LINEAR   = 2'h0;
  // =========================================
  // Implementation capabilities
  localparam logic [1:0] CAP_ST_LEVELS   = 2'h1;
  localparam logic       CAP_TERM_ABORT  = 1'b0;
  localparam logic [1:0] CAP_STALL       = 2'h0;
  localparam logic [1:0] CAP_SEC_STALL   = 2'h0;
  localparam logic       CAP_SECURE      = 1'b1;
  localparam logic       CAP_PCI_SYS     = 1'b1;
  localparam logic [1:0] CAP_ENDIAN      = 2'h0;
  localparam logic       CAP_VXLATE      = 1'b1;
  localparam logic       CAP_CTX2L       = 1'b1;
  localparam logic       CAP_WVM         = 1'b1;
  localparam logic       CAP_VMWILD      = 1'b1;
  localparam logic       CAP_PRI         = 1'b1;
  localparam logic       CAP_XLATE       = 1'b1;
  localparam logic       CAP_WAKE        = 1'b1;
  localparam logic       CAP_SYS_WAKE    = 1'b1;
  localparam logic       CAP_MSI         = 1'b1;
  localparam logic       CAP_WSPACE      = 1'b1;
  localparam logic       CAP_SPLIT_OFF   = 1'b0;
  localparam logic       CAP_ATS         = 1'b1;
  localparam logic       CAP_HYP         = 1'b1;
  localparam logic       CAP_VER32       = 1'b1;
  localparam logic       CAP_DORMANT     = 1'b0;
  localparam logic [1:0] CAP_HWFLAG      = 2'h2;
  localparam logic       CAP_SYS_ATOMIC  = 1'b1;
  localparam logic       CAP_BTM         = 1'b1;
  localparam logic       CAP_SYS_BCAST   = 1'b1;
  localparam logic       CAP_COH         = 1'b1;
  localparam logic       CAP_SYS_COH     = 1'b1;
  localparam logic [1:0] CAP_TTF         = 2'h3;
  localparam logic       CAP_S1          = 1'b1;
  localparam logic       CAP_S2          = 1'b1;
endpackage

// File: src/mcid_stall_sel.sv
// Resolves the non-secure stall-support code.
// Assumes inputs are steady levels in the clk domain.
`timescale 1ns/10ps
module mcid_stall_sel
  import mcid_pkg::*;
(
  input  wire logic       secure_side_present,
  input  wire logic       pci_system,
  input  wire logic [1:0] own_model,
  input  wire logic [1:0] secure_model,
  input  wire logic       nonsecure_stall_disable,
  output logic      [1:0] model,
  output logic            coerced
);
  logic [1:0] base;
  always_comb begin
    base    = own_model;
    coerced = 1'b0;
    // RULE4: secure copy mirror
    if (secure_side_present) begin
      base = secure_model;
      if (secure_model == STALL_BOTH && nonsecure_stall_disable) begin
        base = STALL_NONE;
      end
    end
    model = base;
    // RULE3: reserved code avoided
    if (base == 2'h3) begin
      model   = STALL_NONE;
      coerced = 1'b1;
    end
    // RULE5: no forced stall on PCI
    if (pci_system && base == STALL_FORCED) begin
      model   = STALL_NONE;
      coerced = 1'b1;
    end
  end
endmodule

// File: src/mcid_rd_port.sv
// Read decode and registered read data for the capability registers.
// Assumes one-cycle read strobes; data stand the following cycle only.
`timescale 1ns/10ps
module mcid_rd_port
  import mcid_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              rd,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       feature_word,
  input  wire logic [31:0]       ctrl_word,
  input  wire logic [31:0]       sec_word,
  output logic      [31:0]       rdata
);
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0;
    if (rd) begin
      case (addr)
        OFS_FEATURE0:    rdata_nxt = feature_word;
        OFS_SEC_CTRL:    rdata_nxt = ctrl_word;
        OFS_SEC_FEATURE: rdata_nxt = sec_word;
        default:         rdata_nxt = 32'h0;
      endcase
    end
  end
  // Zero outside the read cycle keeps the data one cycle wide
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;
endmodule

// File: test/mcid_top_monitor.sv
// Concurrent checks on the capability report register port.
// Assumes it is bound to mcid_top and sees only that module's ports.
`timescale 1ns/10ps
module mcid_top_monitor
  import mcid_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic [1:0]        ns_stall_model,
  input wire logic              nonsecure_stall_disable,
  input wire logic              cap_coerced
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rep_rd;
  logic ctl_wr;
  assign rep_rd = reg_rd && reg_addr == OFS_FEATURE0;
  assign ctl_wr = reg_wr && reg_addr == OFS_SEC_CTRL;
  // =========================================
  // Read port
  idle_zero_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not zero outside an answer");
  sec_copy_a: assert property (
    $past(reg_rd && reg_addr == OFS_SEC_FEATURE) |-> reg_rdata == {6'h0, CAP_SEC_STALL, 24'h0})
    else $error("secure copy read wrong");
  // =========================================
  // Stall field
  stall_read_a: assert property (
    $past(rep_rd) |-> reg_rdata[25:24] ==
      (($past(nonsecure_stall_disable) && CAP_SEC_STALL == STALL_BOTH) ? STALL_NONE : CAP_SEC_STALL))
    else $error("stall field read wrong");
  stall_mirror_a: assert property (
    ns_stall_model ==
      (($past(nonsecure_stall_disable) && CAP_SEC_STALL == STALL_BOTH) ? STALL_NONE : CAP_SEC_STALL))
    else $error("stall copy wrong");
  no_forced_a: assert property (
    $past(rep_rd) |-> reg_rdata[25:24] != STALL_FORCED) else $error("forced stall reported");
  ctrl_write_a: assert property (
    $past(ctl_wr) |-> nonsecure_stall_disable == $past(reg_wdata[POS_STALL_DIS]))
    else $error("stall disable not written");
  ctrl_hold_a: assert property (
    !$past(ctl_wr) |-> $stable(nonsecure_stall_disable)) else $error("stall disable moved");
  // =========================================
  // Field encodings and dependencies
  codes_legal_a: assert property (
    $past(rep_rd) |-> !reg_rdata[28] && reg_rdata[22:21] != 2'h1 && reg_rdata[7:6] != 2'h3
      && reg_rdata[3:2] != 2'h0) else $error("reserved code reported");
  xlate_dep_a: assert property (
    $past(rep_rd) |-> !reg_rdata[20] || (reg_rdata[15] && reg_rdata[1] && reg_rdata[0]))
    else $error("virtual translate page without support");
  stage2_dep_a: assert property (
    $past(rep_rd) |-> (!reg_rdata[17] || reg_rdata[0]) && reg_rdata[9] == (reg_rdata[1] && reg_rdata[0]))
    else $error("stage dependent bit wrong");
  ats_dep_a: assert property (
    $past(rep_rd) |-> (!reg_rdata[16] || reg_rdata[10])
      && (!reg_rdata[11] || (reg_rdata[10] && reg_rdata[1] && reg_rdata[0])))
    else $error("ats dependent bit wrong");
  coerce_const_a: assert property (
    $stable(cap_coerced)) else $error("coerce flag moved");
endmodule

// File: test/mcid_top_tb.sv
// Self-checking bench for the capability report register.
// Assumes the register port of mcid_top and the package constants.
`timescale 1ns/10ps
module mcid_top_tb
  import mcid_pkg::*;
  ;
  logic              clk;
  logic              resetn;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic [1:0]        ns_stall_model;
  logic              nonsecure_stall_disable;
  logic              cap_coerced;
  logic [31:0]       lfsr_r;
  logic              ans_due_r;
  logic [31:0]       exp_q[$];
  int                miscompares;
  int                checked;

  mcid_top dut (
    .clk                     (clk),
    .resetn                  (resetn),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .ns_stall_model          (ns_stall_model),
    .nonsecure_stall_disable (nonsecure_stall_disable),
    .cap_coerced             (cap_coerced)
  );

  always #20 clk = ~clk;

  // =========================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] report_exp(input logic dis);
    logic [31:0] w;
    logic [1:0]  st;
    w        = 32'h0;
    st       = CAP_SECURE ? CAP_SEC_STALL : CAP_STALL;
    st       = (CAP_SECURE && st == STALL_BOTH && dis) ? STALL_NONE : st;
    st       = (CAP_PCI_SYS && st == STALL_FORCED) ? STALL_NONE : st;
    w[28:27] = CAP_ST_LEVELS;
    w[26]    = CAP_TERM_ABORT;
    w[25:24] = st;
    w[22:21] = CAP_ENDIAN;
    w[20]    = CAP_VXLATE & CAP_XLATE & CAP_S1 & CAP_S2;
    w[19]    = CAP_CTX2L;
    w[18]    = CAP_WVM;
    w[17]    = CAP_VMWILD & CAP_S2;
    w[16]    = CAP_PRI & CAP_ATS;
    w[15]    = CAP_XLATE;
    w[14]    = CAP_WAKE & CAP_SYS_WAKE;
    w[13]    = CAP_MSI;
    w[12]    = CAP_WSPACE;
    w[11]    = CAP_SPLIT_OFF & CAP_ATS & CAP_S1 & CAP_S2;
    w[10]    = CAP_ATS;
    w[9]     = (CAP_HYP | CAP_VER32) & CAP_S1 & CAP_S2;
    w[8]     = CAP_DORMANT;
    w[7:6]   = CAP_SYS_ATOMIC ? CAP_HWFLAG : FLAG_NONE;
    w[5]     = CAP_BTM & CAP_SYS_BCAST;
    w[4]     = CAP_COH & CAP_SYS_COH;
    w[3:2]   = CAP_TTF;
    w[1]     = CAP_S1;
    w[0]     = CAP_S2;
    return w;
  endfunction

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // =========================================
  // Register port master
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    reg_addr <= a;
    exp_q.push_back(e);
  endtask

  task automatic idle();
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    compare({28'h0, ns_stall_model, nonsecure_stall_disable, cap_coerced}, 32'h0);
    compare(reg_rdata, 32'h0);
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
  endtask

  // =========================================
  // Answer watcher: one note per read strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ans_due_r <= 1'b0;
    end else begin
      ans_due_r <= reg_rd;
    end
  end

  always @(negedge clk) begin
    if (ans_due_r) begin
      compare(reg_rdata, exp_q.pop_front());
    end else if (resetn) begin
      compare(reg_rdata, 32'h0);
    end
  end

  // =========================================
  // Main sequence
  initial begin
    logic [31:0] e;
    logic        coerce_exp;
    clk         = 1'b0;
    resetn      = 1'b0;
    reg_addr    = 12'h000;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    lfsr_r      = 32'hFB573FBE;
    miscompares = 0;
    checked     = 0;
    // Any configured code that the rules reserve or forbid has to be replaced and flagged
    coerce_exp  = CAP_ST_LEVELS[1] || CAP_ENDIAN == 2'h1 || CAP_HWFLAG == 2'h3 || CAP_TTF == 2'h0
                  || (CAP_SECURE ? CAP_SEC_STALL : CAP_STALL) == 2'h3
                  || (CAP_PCI_SYS && (CAP_SECURE ? CAP_SEC_STALL : CAP_STALL) == STALL_FORCED);
    do_reset();
    rd(OFS_FEATURE0, report_exp(1'b0));
    rd(OFS_SEC_FEATURE, {6'h0, CAP_SEC_STALL, 24'h0});
    rd(12'h00C, 32'h0);
    lfsr_r = lfsr_next(lfsr_r);
    wr(OFS_FEATURE0, lfsr_r);
    wr(OFS_SEC_FEATURE, ~lfsr_r);
    rd(OFS_FEATURE0, report_exp(1'b0));
    rd(OFS_SEC_FEATURE, {6'h0, CAP_SEC_STALL, 24'h0});
    for (int i = 0; i < 16; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      e      = report_exp(lfsr_r[POS_STALL_DIS]);
      wr(OFS_SEC_CTRL, lfsr_r);
      wr({lfsr_r[11:4], 4'hC}, ~lfsr_r);
      rd(OFS_FEATURE0, e);
      rd(OFS_SEC_CTRL, {31'h0, lfsr_r[POS_STALL_DIS]});
      rd({lfsr_r[11:4], 4'hC}, 32'h0);
      idle();
      @(negedge clk);
      compare({30'h0, ns_stall_model}, {30'h0, e[25:24]});
      compare({31'h0, nonsecure_stall_disable}, {31'h0, lfsr_r[POS_STALL_DIS]});
      compare({31'h0, cap_coerced}, {31'h0, coerce_exp});
    end
    wr(OFS_SEC_CTRL, 32'h1);
    idle();
    idle();
    do_reset();
    rd(OFS_FEATURE0, report_exp(RST_STALL_DIS));
    idle();
    repeat (3) @(posedge clk);
    give_verdict();
  end

  initial begin
    #(40 * 3000);
    miscompares++;
    give_verdict();
  end
endmodule

bind mcid_top mcid_top_monitor mon (
  .clk                     (clk),
  .resetn                  (resetn),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .reg_wr                  (reg_wr),
  .reg_rd                  (reg_rd),
  .reg_rdata               (reg_rdata),
  .ns_stall_model          (ns_stall_model),
  .nonsecure_stall_disable (nonsecure_stall_disable),
  .cap_coerced             (cap_coerced)
);
